// ===== src/bmc_calib.sv
`timescale 1ns/1ns
// Function
// - temperature from sixth-order polynomial in voltage
// - current equals code times numerator over denominator
// - numerator and denominator handled as integers
// - full scale 2^31 counts means 300 mV
// - current times one plus gain over 100000
// - current gain clamped to signed bound
// - voltage scaled by ratio, default 1/1414
// - voltage times one plus gain over 100000
// - voltage gain clamped to signed bound
// - at rest unless current magnitude exceeds threshold
// - charge accumulates on every current sample
// - variant code 0, 1, 2 selects interface
// - module count held and used for indexing
// - supply source: 0 cells, 1 controller
module bmc_calib (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // raw samples
  input wire logic cur_valid_i,
  input wire logic signed [31:0] cur_code_i,
  input wire logic volt_valid_i,
  input wire logic signed [31:0] volt_code_i,
  input wire logic therm_valid_i,
  input wire logic signed [31:0] therm_v_i,
  // calibrated results
  output logic current_valid_o,
  output logic signed [31:0] current_o,
  output logic voltage_valid_o,
  output logic signed [31:0] voltage_o,
  output logic temp_valid_o,
  output logic signed [31:0] temp_o,
  output logic [31:0] temp_module_o,
  // charge state
  output logic at_rest_o,
  output logic charging_o,
  output logic discharging_o,
  // hardware settings
  output bmc_pkg::bmc_variant_t variant_o,
  output logic [31:0] module_total_o,
  output logic supply_src_o
);
  import bmc_pkg::*;

  typedef enum {BMC_IDLE, BMC_RUN} bmc_state_t;

  logic [31:0] cfg_r [NCFG];
  logic wr_hit;
  logic rd_hit;
  logic [4:0] widx;
  logic signed [63:0] charge_r;
  logic signed [31:0] cur_scaled;
  logic signed [31:0] volt_scaled;
  logic signed [32:0] cur_mag;
  logic signed [32:0] out_mag;
  logic signed [32:0] cur_geff;
  bmc_state_t state_r;
  logic [2:0] step_r;
  logic signed [31:0] acc_r;
  logic signed [31:0] tv_r;
  logic signed [63:0] hprod;
  logic signed [31:0] horner_nxt;
  logic [31:0] mod_idx_r;

  // clamp a signed gain to plus or minus an absolute bound
  function automatic logic signed [32:0] clamp_gain(
    input logic signed [31:0] gain,
    input logic [31:0] lim
  );
    logic signed [32:0] l;
    logic signed [32:0] g;
    l = $signed({1'b0, lim});
    g = {gain[31], gain};
    if (g > l) begin
      g = l;
    end else if (g < -l) begin
      g = -l;
    end
    return g;
  endfunction

  // ratio then field gain; 100 bits keep every full-scale case exact
  function automatic logic signed [31:0] scale(
    input logic signed [31:0] code,
    input logic signed [31:0] num,
    input logic [31:0] den,
    input logic signed [32:0] geff
  );
    logic signed [99:0] t;
    t = 100'(code) * 100'(num);
    if (den == 32'h0) begin
      t = '0; // zero divider is unconfigured, report zero not garbage
    end else begin
      t = t / $signed({68'h0, den});
    end
    t = t * (100'(geff) + 100'(GAIN_UNIT));
    t = t / 100'(GAIN_UNIT);
    if (t > 100'(32'sh7FFF_FFFF)) begin
      t = 100'(32'sh7FFF_FFFF);
    end else if (t < -100'(32'sh7FFF_FFFF) - 100'(1)) begin
      t = -100'(32'sh7FFF_FFFF) - 100'(1);
    end
    return t[31:0];
  endfunction

  // bus decode; writes land when the request is first seen
  assign wr_hit = cyc_i && stb_i && we_i && !ack_o;
  assign rd_hit = cyc_i && stb_i && !we_i && !ack_o;
  assign widx = adr_i[6:2];

  // one-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // configuration words with byte lanes, one per index
  for (genvar i = 0; i < NCFG; i++) begin : g_cfg
    localparam logic [31:0] RV = (i == IX_VNUM) ? RST_VNUM :
                                 (i == IX_VDEN) ? RST_VDEN : RST_ZERO;
    logic blocked;
    // variant code 3 selects nothing, so such a write is dropped
    assign blocked = (i == IX_VARIANT) && (dat_i[1:0] == 2'h3);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_r[i] <= RV;
      end else if (wr_hit && adr_i[7] == 1'b0 && widx == 5'(i) && !blocked) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) begin
            cfg_r[i][8*b +: 8] <= dat_i[8*b +: 8];
          end
        end
      end
    end
  end

  // read mux; unmapped offsets read zero and still acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      case (adr_i)
        OFS_STATUS: dat_o <= {28'h0, state_r == BMC_RUN, discharging_o,
                              charging_o, at_rest_o};
        OFS_CUR: dat_o <= current_o;
        OFS_VOLT: dat_o <= voltage_o;
        OFS_TEMP: dat_o <= temp_o;
        OFS_CHG_LO: dat_o <= charge_r[31:0];
        OFS_CHG_HI: dat_o <= charge_r[63:32];
        default: begin
          if (adr_i < OFS_STATUS && adr_i[1:0] == 2'h0) begin
            dat_o <= cfg_r[widx];
          end else begin
            dat_o <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // current path: integer ratio, then bounded field gain
  assign cur_geff = clamp_gain(cfg_r[IX_CGAIN], cfg_r[IX_CBOUND]);
  assign cur_scaled = scale(cur_code_i, cfg_r[IX_CNUM], cfg_r[IX_CDEN], cur_geff);
  assign cur_mag = cur_scaled[31] ? -33'(cur_scaled) : 33'(cur_scaled);
  assign out_mag = current_o[31] ? -33'(current_o) : 33'(current_o);

  // current result and charge-state classification
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_o <= 32'sh0;
      current_valid_o <= 1'b0;
      at_rest_o <= 1'b1;
      charging_o <= 1'b0;
      discharging_o <= 1'b0;
    end else begin
      current_valid_o <= cur_valid_i;
      if (cur_valid_i) begin
        current_o <= cur_scaled;
        // the deadband hides sensor noise around zero
        at_rest_o <= !(cur_mag > $signed({1'b0, cfg_r[IX_REST]}));
        charging_o <= (cur_mag > $signed({1'b0, cfg_r[IX_REST]})) && !cur_scaled[31];
        discharging_o <= (cur_mag > $signed({1'b0, cfg_r[IX_REST]})) && cur_scaled[31];
      end
    end
  end

  // coulomb count ignores the deadband entirely
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_r <= 64'sh0;
    end else if (cur_valid_i) begin
      charge_r <= charge_r + 64'(cur_scaled);
    end
  end

  // voltage path mirrors the current path
  assign volt_scaled = scale(volt_code_i, cfg_r[IX_VNUM], cfg_r[IX_VDEN],
                             clamp_gain(cfg_r[IX_VGAIN], cfg_r[IX_VBOUND]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      voltage_o <= 32'sh0;
      voltage_valid_o <= 1'b0;
    end else begin
      voltage_valid_o <= volt_valid_i;
      if (volt_valid_i) begin
        voltage_o <= volt_scaled;
      end
    end
  end

  // horner step; one multiplier reused six times instead of six copies
  assign hprod = 64'(acc_r) * 64'(tv_r);
  assign horner_nxt = hprod[FRAC_BITS +: 32] + $signed(cfg_r[step_r - 3'h1]);

  // polynomial sequencer; samples arriving while busy are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= BMC_IDLE;
      step_r <= 3'h0;
      acc_r <= 32'sh0;
      tv_r <= 32'sh0;
      temp_o <= 32'sh0;
      temp_valid_o <= 1'b0;
    end else begin
      temp_valid_o <= 1'b0;
      case (state_r)
        BMC_IDLE: begin
          if (therm_valid_i) begin
            acc_r <= $signed(cfg_r[6]);
            tv_r <= therm_v_i;
            step_r <= POLY_ORDER;
            state_r <= BMC_RUN;
          end
        end
        BMC_RUN: begin
          acc_r <= horner_nxt;
          step_r <= step_r - 3'h1;
          if (step_r == 3'h1) begin
            temp_o <= horner_nxt;
            temp_valid_o <= 1'b1;
            state_r <= BMC_IDLE;
          end
        end
        default: state_r <= BMC_IDLE;
      endcase
    end
  end

  // module index of each thermistor sample wraps at the module count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_idx_r <= 32'h0;
      temp_module_o <= 32'h0;
    end else if (state_r == BMC_IDLE && therm_valid_i) begin
      temp_module_o <= mod_idx_r;
      if (mod_idx_r + 32'h1 >= cfg_r[IX_MODTOT]) begin
        mod_idx_r <= 32'h0;
      end else begin
        mod_idx_r <= mod_idx_r + 32'h1;
      end
    end
  end

  // hardware settings driven out from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      variant_o <= BMC_VAR_A;
      module_total_o <= 32'h0;
      supply_src_o <= 1'b0;
    end else begin
      variant_o <= bmc_variant_t'(cfg_r[IX_VARIANT][1:0]);
      module_total_o <= cfg_r[IX_MODTOT];
      supply_src_o <= cfg_r[IX_SUPPLY][0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_rest_band: assert property (
    current_valid_o |-> at_rest_o == (out_mag <= $signed({1'b0, $past(cfg_r[IX_REST])})))
    else $error("rest flag disagrees with deadband");
  a_charge_dir: assert property (
    current_valid_o && !at_rest_o |-> charging_o == !current_o[31]
      && discharging_o == current_o[31])
    else $error("charge direction wrong");
  a_coulomb_count: assert property (
    cur_valid_i |=> charge_r == $past(charge_r) + 64'(current_o))
    else $error("charge not accumulated");
  a_unit_ratio: assert property (
    cur_valid_i && cfg_r[IX_CNUM] == cfg_r[IX_CDEN] && cfg_r[IX_CDEN] != 32'h0
      && cfg_r[IX_CBOUND] == 32'h0 |=> current_o == $past(cur_code_i))
    else $error("unit ratio changed current");
  a_gain_bound: assert property (
    cur_geff <= $signed({1'b0, cfg_r[IX_CBOUND]})
      && cur_geff >= -$signed({1'b0, cfg_r[IX_CBOUND]}))
    else $error("current gain beyond bound");
  a_volt_default: assert property (
    $past(rst_i) |-> cfg_r[IX_VNUM] == RST_VNUM && cfg_r[IX_VDEN] == RST_VDEN)
    else $error("voltage ratio default wrong");
  a_volt_gain: assert property (
    volt_valid_i && volt_code_i == 32'sd100000 && cfg_r[IX_VNUM] == cfg_r[IX_VDEN]
      && cfg_r[IX_VDEN] != 32'h0 && cfg_r[IX_VGAIN] == 32'sd1000
      && cfg_r[IX_VBOUND] >= 32'd1000 |=> voltage_o == 32'sd101000)
    else $error("voltage field gain wrong");
  a_poly_time: assert property (
    state_r == BMC_IDLE && therm_valid_i |-> ##7 temp_valid_o)
    else $error("temperature late");
  a_variant_code: assert property (variant_o != 2'h3)
    else $error("illegal variant");
  a_module_wrap: assert property (
    temp_valid_o |-> temp_module_o < module_total_o || temp_module_o == 32'h0)
    else $error("module index out of range");

  c_charging: cover property (current_valid_o && charging_o);
  c_resting: cover property (current_valid_o && at_rest_o);
  c_temp_done: cover property (temp_valid_o);
  c_volt_done: cover property (voltage_valid_o);
endmodule

// ===== src/bmc_pkg.sv
package bmc_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_COEFF0 = 8'h00; // coefficients 0..6 follow
  localparam logic [7:0] OFS_CNUM = 8'h1C;
  localparam logic [7:0] OFS_CDEN = 8'h20;
  localparam logic [7:0] OFS_CGAIN = 8'h24;
  localparam logic [7:0] OFS_CBOUND = 8'h28;
  localparam logic [7:0] OFS_REST = 8'h2C;
  localparam logic [7:0] OFS_VNUM = 8'h30;
  localparam logic [7:0] OFS_VDEN = 8'h34;
  localparam logic [7:0] OFS_VGAIN = 8'h38;
  localparam logic [7:0] OFS_VBOUND = 8'h3C;
  localparam logic [7:0] OFS_VARIANT = 8'h40;
  localparam logic [7:0] OFS_MODTOT = 8'h44;
  localparam logic [7:0] OFS_SUPPLY = 8'h48;
  localparam logic [7:0] OFS_STATUS = 8'h4C;
  localparam logic [7:0] OFS_CUR = 8'h50;
  localparam logic [7:0] OFS_VOLT = 8'h54;
  localparam logic [7:0] OFS_TEMP = 8'h58;
  localparam logic [7:0] OFS_CHG_LO = 8'h5C;
  localparam logic [7:0] OFS_CHG_HI = 8'h60;
  // writable word indices (offset / 4)
  localparam int NCFG = 19;
  localparam int IX_CNUM = 7;
  localparam int IX_CDEN = 8;
  localparam int IX_CGAIN = 9;
  localparam int IX_CBOUND = 10;
  localparam int IX_REST = 11;
  localparam int IX_VNUM = 12;
  localparam int IX_VDEN = 13;
  localparam int IX_VGAIN = 14;
  localparam int IX_VBOUND = 15;
  localparam int IX_VARIANT = 16;
  localparam int IX_MODTOT = 17;
  localparam int IX_SUPPLY = 18;
  // reset values
  localparam logic [31:0] RST_VNUM = 32'h0000_0001;
  localparam logic [31:0] RST_VDEN = 32'h0000_0586;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // field gain unit: gain / 100000 is the fraction
  localparam int GAIN_UNIT = 100000;
  // fixed point of coefficients and thermistor voltage
  localparam int FRAC_BITS = 16;
  localparam logic [2:0] POLY_ORDER = 3'h6;
  // status word bits
  localparam int ST_REST = 0;
  localparam int ST_CHG = 1;
  localparam int ST_DIS = 2;
  localparam int ST_BUSY = 3;
  // cell interface variant codes
  typedef enum logic [1:0] {
    BMC_VAR_A = 2'h0,
    BMC_VAR_B = 2'h1,
    BMC_VAR_C = 2'h2
  } bmc_variant_t;
endpackage

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
  import bmc_pkg::*;
  // stimulus, all given a value at time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic cur_valid_i = 1'b0;
  logic volt_valid_i = 1'b0;
  logic therm_valid_i = 1'b0;
  logic signed [31:0] cur_code_i = 32'sh0;
  logic signed [31:0] volt_code_i = 32'sh0;
  logic signed [31:0] therm_v_i = 32'sh0;
  // observed
  logic [31:0] dat_o, module_total_o, temp_module_o;
  logic signed [31:0] current_o, voltage_o, temp_o;
  logic ack_o, current_valid_o, voltage_valid_o, temp_valid_o;
  logic at_rest_o, charging_o, discharging_o, supply_src_o;
  bmc_variant_t variant_o;
  // bookkeeping
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h7;
  logic [63:0] rd_q[$], cur_q[$], volt_q[$], temp_q[$];
  logic [31:0] coef[7];
  longint chg = 0;

  bmc_calib u_bmc_calib (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .cur_valid_i(cur_valid_i), .cur_code_i(cur_code_i), .volt_valid_i(volt_valid_i),
    .volt_code_i(volt_code_i), .therm_valid_i(therm_valid_i), .therm_v_i(therm_v_i),
    .current_valid_o(current_valid_o), .current_o(current_o),
    .voltage_valid_o(voltage_valid_o), .voltage_o(voltage_o),
    .temp_valid_o(temp_valid_o), .temp_o(temp_o), .temp_module_o(temp_module_o),
    .at_rest_o(at_rest_o), .charging_o(charging_o), .discharging_o(discharging_o),
    .variant_o(variant_o), .module_total_o(module_total_o), .supply_src_o(supply_src_o)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  // 64-bit math so full-scale codes cannot wrap before saturation
  function automatic longint cal(longint code, longint num, longint den, longint gn,
                                 longint bnd);
    longint r;
    if (gn > bnd) gn = bnd;
    if (gn < -bnd) gn = -bnd;
    r = (den == 0) ? 0 : code * num / den;
    r = r * (GAIN_UNIT + gn) / GAIN_UNIT;
    if (r > 64'sh7FFF_FFFF) r = 64'sh7FFF_FFFF;
    if (r < -64'sh8000_0000) r = -64'sh8000_0000;
    return r;
  endfunction

  // horner in q16.16, wrapping like a 32-bit accumulator
  function automatic logic [31:0] horner(logic [31:0] v);
    logic [31:0] acc;
    longint p;
    acc = coef[6];
    for (int k = 5; k >= 0; k--) begin
      p = longint'($signed(acc)) * longint'($signed(v));
      acc = p[47:16] + coef[k];
    end
    return acc;
  endfunction

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic single cycle; a read leaves its expected word as a note
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [31:0] e);
    int n;
    n = 0;
    if (!w) rd_q.push_back({32'h0, e});
    adr_i <= a;
    dat_i <= d;
    we_i <= w;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    // a request left unanswered counts as a mismatch
    if (ack_o !== 1'b1) fails++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // monitor: a result with no note left is compared against all ones
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      check("rdata", dat_o, rd_q.size() ? rd_q.pop_front() : '1);
    if (current_valid_o === 1'b1)
      check("current", {at_rest_o, charging_o, discharging_o, current_o},
            cur_q.size() ? cur_q.pop_front() : '1);
    if (voltage_valid_o === 1'b1)
      check("voltage", {voltage_o}, volt_q.size() ? volt_q.pop_front() : '1);
    if (temp_valid_o === 1'b1)
      check("temp", {temp_module_o, temp_o}, temp_q.size() ? temp_q.pop_front() : '1);
  end

  // watchdog: the sequence needs under 3000 cycles
  initial begin
    #100000;
    fails++;
    results();
  end

  // main sequence
  initial begin
    int unsigned den, bnd, thr;
    int num, gn, code;
    longint r;
    logic rs;
    logic [31:0] tv;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped and read-only places
    wb(OFS_VNUM, 1'b0, 0, RST_VNUM);
    wb(OFS_VDEN, 1'b0, 0, RST_VDEN);
    wb(OFS_CNUM, 1'b0, 0, RST_ZERO);
    wb(8'h80, 1'b1, 32'hA5A5_A5A5, 0);
    wb(8'h80, 1'b0, 0, 0);
    wb(OFS_CUR, 1'b1, 32'h1234_5678, 0);
    wb(OFS_CUR, 1'b0, 0, 0);
    // current: random ratio, gain, bound, deadband; last round saturates
    for (int i = 0; i < 8; i++) begin
      num = int'(xs() % 1000) + 2;
      den = (i == 7) ? 1 : xs() % 5000 + 1;
      gn = int'(xs() % 8001) - 4000;
      bnd = xs() % 3000;
      thr = xs() % 30000;
      if (i == 6) begin
        // unit ratio with zero bound must pass the code straight through
        num = 7;
        den = 7;
        bnd = 0;
      end
      wb(OFS_CNUM, 1'b1, num, 0);
      wb(OFS_CDEN, 1'b1, den, 0);
      wb(OFS_CGAIN, 1'b1, gn, 0);
      wb(OFS_CBOUND, 1'b1, bnd, 0);
      wb(OFS_REST, 1'b1, thr, 0);
      for (int j = 0; j < 3; j++) begin
        code = (i == 7 && j == 0) ? 32'sh7FFF_FFFF : int'(xs() % 262144) - 131072;
        r = cal(code, num, den, gn, bnd);
        chg += r;
        rs = !((r < 0 ? -r : r) > thr);
        cur_q.push_back({rs, !rs && r >= 0, !rs && r < 0, r[31:0]});
        cur_valid_i <= 1'b1;
        cur_code_i <= code;
        @(posedge clk_i);
      end
      cur_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    // status and current words over the bus reflect the last sample
    wb(OFS_STATUS, 1'b0, 0, {28'h0, 1'b0, !rs && r < 0, !rs && r >= 0, rs});
    wb(OFS_CUR, 1'b0, 0, r[31:0]);
    // voltage on the default ratio, then a unit ratio; bound 0 and 800 force the clamp
    for (int i = 0; i < 4; i++) begin
      gn = (i == 1) ? -1000 : 1000;
      bnd = (i == 0) ? 0 : (i == 1 ? 800 : 5000);
      den = (i == 3) ? 1 : 1414;
      wb(OFS_VGAIN, 1'b1, gn, 0);
      wb(OFS_VBOUND, 1'b1, bnd, 0);
      if (i == 3) wb(OFS_VDEN, 1'b1, den, 0);
      for (int j = 0; j < 3; j++) begin
        code = (i == 3 && j == 0) ? 100000 : int'(xs() % 16777216) - 8388608;
        r = cal(code, 1, den, gn, bnd);
        volt_q.push_back({32'h0, r[31:0]});
        volt_valid_i <= 1'b1;
        volt_code_i <= code;
        @(posedge clk_i);
      end
      volt_valid_i <= 1'b0;
    end
    // thermistor over three modules; a second pulse while busy is dropped
    wb(OFS_MODTOT, 1'b1, 3, 0);
    for (int k = 0; k < 7; k++) begin
      coef[k] = int'(xs() % 131072) - 65536;
      wb(OFS_COEFF0 + 8'(4 * k), 1'b1, coef[k], 0);
    end
    for (int n = 0; n < 4; n++) begin
      tv = xs() % 262144;
      temp_q.push_back({32'(n % 3), horner(tv)});
      therm_valid_i <= 1'b1;
      therm_v_i <= tv;
      @(posedge clk_i);
      if (n == 1) begin
        therm_v_i <= xs();
        @(posedge clk_i);
      end
      therm_valid_i <= 1'b0;
      for (int w = 0; w < 20 && temp_valid_o !== 1'b1; w++) @(posedge clk_i);
      @(posedge clk_i);
    end
    // settings: code 3 must leave the variant alone
    for (int k = 0; k < 4; k++) begin
      wb(OFS_VARIANT, 1'b1, k, 0);
      wb(OFS_SUPPLY, 1'b1, k, 0);
      wb(OFS_MODTOT, 1'b1, k + 5, 0);
      check("variant", variant_o, (k == 3) ? 2 : k);
      check("supply", supply_src_o, k % 2);
      check("modules", module_total_o, k + 5);
    end
    wb(OFS_VARIANT, 1'b0, 0, 2);
    wb(OFS_CHG_LO, 1'b0, 0, chg[31:0]);
    wb(OFS_CHG_HI, 1'b0, 0, chg[63:32]);
    check("notes", rd_q.size() + cur_q.size() + volt_q.size() + temp_q.size(), 0);
    results();
  end
endmodule
